// >>> dlc_pkg.sv
// Package of register offsets, field positions, reset values and timing for the line control block.
// Function
// - Negative ring flag reads live ring state.
// - Positive ring flag reads live ring state.
// - Ring indicator clears 4.5-9 s or off-hook.
// - Monitor enable selects low-power on-hook monitoring.
// - Off-hook request ORed with enabled pin.
// - Mode bit set skips off-hook timeout counter.
// - Transmit attenuation code drives call-progress output.
// - Receive attenuation code drives call-progress output.
// - Line-side powerdown bit drives low-power mode.
// - System powerdown holds until internal reset.
package dlc_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam int IDX_LINE_CTRL = 5;
   localparam int IDX_LEVEL_CTRL = 6;
   localparam int IDX_RSVD7 = 7;
   localparam logic [7:0] ADDR_LINE_CTRL = 8'(IDX_LINE_CTRL * 4);
   localparam logic [7:0] ADDR_LEVEL_CTRL = 8'(IDX_LEVEL_CTRL * 4);
   localparam logic [7:0] ADDR_RSVD7 = 8'(IDX_RSVD7 * 4);
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam logic [7:0] ADDR_PIN_CTRL = 8'h28;
   localparam int BIT_RING_NEG = 6;
   localparam int BIT_RING_POS = 5;
   localparam int BIT_MONITOR = 3;
   localparam int BIT_RING_IND = 2;
   localparam int BIT_OFFHOOK = 0;
   localparam int BIT_TX_HI = 6;
   localparam int BIT_RX_HI = 5;
   localparam int BIT_LINE_PD = 4;
   localparam int BIT_SYS_PD = 3;
   localparam int BIT_TX_LO = 1;
   localparam int BIT_RX_LO = 0;
   localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
   localparam logic [7:0] LEVEL_CTRL_RESET = 8'h70;
   localparam logic [7:0] LINE_CTRL_WMASK = 8'h09;
   localparam logic [7:0] LEVEL_CTRL_WMASK = 8'h7b;
   localparam int IRQ_RING = 0;
   localparam int IRQ_RING_END = 1;
   localparam int IRQ_OFFHOOK = 2;
   localparam int IRQ_W = 3;
   localparam int CLK_HZ = 200000000;
   localparam int RING_HOLD_MS = 6000;
   localparam longint RING_HOLD_CYC = longint'(RING_HOLD_MS) * CLK_HZ / 1000;
   localparam int OFFHOOK_TIMEOUT_MS = 250;
   localparam longint OFFHOOK_TIMEOUT_CYC = longint'(OFFHOOK_TIMEOUT_MS) * CLK_HZ / 1000;
   localparam int CNT_W = 32;
endpackage

// >>> dlc_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module dlc_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Data.
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage1_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage1_ff <= '0;
         syncOut <= '0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut <= stage1_ff;
      end
   end
endmodule

// >>> dlc_line_control_regs.sv
// Line hook, ring and call-progress control registers behind an APB slave.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dlc_line_control_regs #(
   parameter logic [31:0] RING_HOLD = 32'(dlc_pkg::RING_HOLD_CYC),
   parameter logic [31:0] OFFHOOK_TIMEOUT = 32'(dlc_pkg::OFFHOOK_TIMEOUT_CYC)
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Line-side status pins.
   input wire logic ringNegIn,
   input wire logic ringPosIn,
   input wire logic offhookPinIn,
   input wire logic modeSelIn,
   input wire logic softResetIn,
   // Line-side controls.
   output logic offhookOut,
   output logic monitorOut,
   output logic [1:0] txAttenOut,
   output logic [1:0] rxAttenOut,
   output logic txMuteOut,
   output logic rxMuteOut,
   output logic linePowerdownOut,
   output logic sysPowerdownOut,
   output logic irqOut
);
   logic ringNeg;
   logic ringPos;
   logic offhookPin;
   logic modeSel;
   logic softReset;
   logic [7:0] lineCtrl_ff;
   logic [7:0] levelCtrl_ff;
   logic [7:0] pinCtrl_ff;
   logic ringInd_ff;
   logic ringPosDly_ff;
   logic [31:0] ringCnt_ff;
   logic [31:0] hookCnt_ff;
   logic hookWait_ff;
   logic offhookEff;
   logic offhookDly_ff;
   logic [dlc_pkg::IRQ_W-1:0] irqStatus_ff;
   logic [dlc_pkg::IRQ_W-1:0] irqMask_ff;
   logic [dlc_pkg::IRQ_W-1:0] irqEvent;
   logic wrEn;
   logic rdEn;
   logic regRst;
   logic [31:0] nxt_rdata;
   logic ringEnd;

   dlc_sync #(.W(5)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn({ringNegIn, ringPosIn, offhookPinIn, modeSelIn, softResetIn}),
      .syncOut({ringNeg, ringPos, offhookPin, modeSel, softReset})
   );

   // Software reset returns the registers to their reset values as a full reset would.
   assign regRst = rst | softReset;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & ~penable & ~pwrite;

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         lineCtrl_ff <= dlc_pkg::LINE_CTRL_RESET;
      end else if (wrEn && paddr == dlc_pkg::ADDR_LINE_CTRL) begin
         lineCtrl_ff <= pwdata[7:0] & dlc_pkg::LINE_CTRL_WMASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         levelCtrl_ff <= dlc_pkg::LEVEL_CTRL_RESET;
      end else if (wrEn && paddr == dlc_pkg::ADDR_LEVEL_CTRL) begin
         // The system powerdown bit is sticky until reset; software cannot clear it.
         levelCtrl_ff <= (pwdata[7:0] & dlc_pkg::LEVEL_CTRL_WMASK)
            | (levelCtrl_ff & 8'h08);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         pinCtrl_ff <= 8'h00;
      end else if (wrEn && paddr == dlc_pkg::ADDR_PIN_CTRL) begin
         pinCtrl_ff <= {7'h00, pwdata[0]};
      end
   end

   // Effective hook state: register request ORed with the pin when the pin is enabled.
   assign offhookEff = lineCtrl_ff[dlc_pkg::BIT_OFFHOOK] | (pinCtrl_ff[0] & offhookPin);

   // Off-hook timeout: after going on-hook, going off-hook again waits for the counter.
   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         offhookDly_ff <= 1'b0;
         hookWait_ff <= 1'b0;
         hookCnt_ff <= 32'h0;
      end else begin
         offhookDly_ff <= offhookOut;
         if (offhookDly_ff && !offhookOut && !modeSel) begin
            hookWait_ff <= 1'b1;
            hookCnt_ff <= OFFHOOK_TIMEOUT;
         end else if (hookWait_ff && hookCnt_ff <= 32'h1) begin
            hookWait_ff <= 1'b0;
            hookCnt_ff <= 32'h0;
         end else if (hookWait_ff) begin
            hookCnt_ff <= hookCnt_ff - 32'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         offhookOut <= 1'b0;
      end else if (!offhookEff) begin
         offhookOut <= 1'b0;
      end else if (!hookWait_ff) begin
         offhookOut <= 1'b1;
      end
   end

   // Ring indicator: set on ringing, held while rings recur, cleared after hold or off-hook.
   assign ringEnd = ringInd_ff && !ringPos && !ringNeg && ringCnt_ff == 32'h1;

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         ringInd_ff <= 1'b0;
         ringPosDly_ff <= 1'b0;
         ringCnt_ff <= 32'h0;
      end else begin
         ringPosDly_ff <= ringPos;
         if (offhookOut) begin
            ringInd_ff <= 1'b0;
            ringCnt_ff <= 32'h0;
         end else if (ringPos || ringNeg) begin
            ringInd_ff <= 1'b1;
            ringCnt_ff <= RING_HOLD;
         end else if (ringEnd) begin
            ringInd_ff <= 1'b0;
            ringCnt_ff <= 32'h0;
         end else if (ringCnt_ff != 32'h0) begin
            ringCnt_ff <= ringCnt_ff - 32'h1;
         end
      end
   end

   // Control outputs follow the registers.
   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         // Outputs match the register reset value so the call-progress paths stay muted.
         monitorOut <= 1'b0;
         txAttenOut <= 2'h2;
         rxAttenOut <= 2'h2;
         txMuteOut <= 1'b1;
         rxMuteOut <= 1'b1;
         linePowerdownOut <= 1'b1;
         sysPowerdownOut <= 1'b0;
      end else begin
         monitorOut <= lineCtrl_ff[dlc_pkg::BIT_MONITOR];
         txAttenOut <= {levelCtrl_ff[dlc_pkg::BIT_TX_HI], levelCtrl_ff[dlc_pkg::BIT_TX_LO]};
         rxAttenOut <= {levelCtrl_ff[dlc_pkg::BIT_RX_HI], levelCtrl_ff[dlc_pkg::BIT_RX_LO]};
         txMuteOut <= levelCtrl_ff[dlc_pkg::BIT_TX_HI] & ~levelCtrl_ff[dlc_pkg::BIT_TX_LO];
         rxMuteOut <= levelCtrl_ff[dlc_pkg::BIT_RX_HI] & ~levelCtrl_ff[dlc_pkg::BIT_RX_LO];
         linePowerdownOut <= levelCtrl_ff[dlc_pkg::BIT_LINE_PD];
         sysPowerdownOut <= levelCtrl_ff[dlc_pkg::BIT_SYS_PD];
      end
   end

   // Interrupt events: positive ring start, ring indicator expiry, hook change.
   assign irqEvent = {offhookOut ^ offhookDly_ff, ringEnd, ringPos & ~ringPosDly_ff};

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         irqStatus_ff <= '0;
      end else if (wrEn && paddr == dlc_pkg::ADDR_IRQ_STATUS) begin
         // A new event in the clearing cycle wins over the clear.
         irqStatus_ff <= (irqStatus_ff & ~pwdata[dlc_pkg::IRQ_W-1:0]) | irqEvent;
      end else begin
         irqStatus_ff <= irqStatus_ff | irqEvent;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         irqMask_ff <= '0;
      end else if (wrEn && paddr == dlc_pkg::ADDR_IRQ_MASK) begin
         irqMask_ff <= pwdata[dlc_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (regRst) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= |(irqStatus_ff & irqMask_ff);
      end
   end

   // Read mux; status bits are live.
   always_comb begin
      nxt_rdata = 32'h0;
      case (paddr)
         dlc_pkg::ADDR_LINE_CTRL: begin
            nxt_rdata[7:0] = lineCtrl_ff;
            nxt_rdata[dlc_pkg::BIT_RING_NEG] = ringNeg;
            nxt_rdata[dlc_pkg::BIT_RING_POS] = ringPos;
            nxt_rdata[dlc_pkg::BIT_RING_IND] = ringInd_ff;
         end
         dlc_pkg::ADDR_LEVEL_CTRL: begin
            nxt_rdata[7:0] = levelCtrl_ff;
         end
         dlc_pkg::ADDR_RSVD7: begin
            nxt_rdata = 32'h0;
         end
         dlc_pkg::ADDR_IRQ_STATUS: begin
            nxt_rdata[dlc_pkg::IRQ_W-1:0] = irqStatus_ff;
         end
         dlc_pkg::ADDR_IRQ_MASK: begin
            nxt_rdata[dlc_pkg::IRQ_W-1:0] = irqMask_ff;
         end
         dlc_pkg::ADDR_PIN_CTRL: begin
            nxt_rdata[0] = pinCtrl_ff[0];
         end
         default: begin
            nxt_rdata = 32'h0;
         end
      endcase
   end

   // Zero-wait slave: data latched in setup, pready high through the access phase.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (rdEn) begin
            prdata <= nxt_rdata;
         end
      end
   end

   a_ring_off_clear: assert property (@(posedge clk_sys) disable iff (regRst)
      offhookOut |=> !ringInd_ff)
      else $error("Ring indicator stayed set while off-hook.");

   a_ring_set: assert property (@(posedge clk_sys) disable iff (regRst)
      (ringPos && !offhookOut) |=> ringInd_ff)
      else $error("Ring indicator not set on ringing.");

   a_hook_or: assert property (@(posedge clk_sys) disable iff (regRst)
      (!offhookEff) |=> !offhookOut)
      else $error("Line stayed off-hook without request.");

   a_hook_go: assert property (@(posedge clk_sys) disable iff (regRst)
      (offhookEff && !hookWait_ff) |=> offhookOut)
      else $error("Off-hook request not honoured.");

   a_mode_nowait: assert property (@(posedge clk_sys) disable iff (regRst)
      (offhookDly_ff && !offhookOut && modeSel && !hookWait_ff) |=> !hookWait_ff)
      else $error("Timeout counter started with mode bit set.");

   a_tx_mute: assert property (@(posedge clk_sys) disable iff (regRst)
      (txAttenOut == 2'h2) |-> txMuteOut)
      else $error("Transmit mute code did not mute.");

   a_rx_mute: assert property (@(posedge clk_sys) disable iff (regRst)
      (rxAttenOut == 2'h2) |-> rxMuteOut)
      else $error("Receive mute code did not mute.");

   a_line_pd: assert property (@(posedge clk_sys) disable iff (regRst)
      ##2 linePowerdownOut == $past(levelCtrl_ff[dlc_pkg::BIT_LINE_PD]))
      else $error("Line powerdown output does not follow register.");

   a_sys_pd_hold: assert property (@(posedge clk_sys) disable iff (regRst)
      levelCtrl_ff[dlc_pkg::BIT_SYS_PD] |=> levelCtrl_ff[dlc_pkg::BIT_SYS_PD])
      else $error("System powerdown cleared without reset.");

   a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (regRst)
      (lineCtrl_ff & ~dlc_pkg::LINE_CTRL_WMASK) == 8'h00)
      else $error("Reserved bit stored a write.");

   a_level_rsvd: assert property (@(posedge clk_sys) disable iff (regRst)
      (levelCtrl_ff & ~dlc_pkg::LEVEL_CTRL_WMASK) == 8'h00)
      else $error("Reserved level bit stored a write.");

   a_ring_expire: assert property (@(posedge clk_sys) disable iff (regRst)
      ringEnd |=> !ringInd_ff)
      else $error("Ring indicator stayed set after its hold time.");

   a_monitor: assert property (@(posedge clk_sys) disable iff (regRst)
      ##1 monitorOut == $past(lineCtrl_ff[dlc_pkg::BIT_MONITOR]))
      else $error("Monitor output does not follow register.");
endmodule

// >>> dlc_line_model.sv
// Line-side model that presents ring signals to the block's ring inputs.
`timescale 1ns/1ps
module dlc_line_model (
   // Clock.
   input wire logic clk_sys,
   // Ring signals toward the block.
   output logic ringPos,
   output logic ringNeg
);
   initial begin
      ringPos = 1'b0;
      ringNeg = 1'b0;
   end
   // One ring burst of one polarity; the line is quiet again when it returns.
   task automatic ring(input logic pos, input int len);
      @(posedge clk_sys);
      ringPos <= pos;
      ringNeg <= !pos;
      repeat (len) @(posedge clk_sys);
      ringPos <= 1'b0;
      ringNeg <= 1'b0;
   endtask
endmodule

// >>> tb_daa_line_control_regs.sv
// Testbench of the line control register block.
`timescale 1ns/1ps
module tb_daa_line_control_regs;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ringNegIn, ringPosIn;
   logic offhookPinIn = 1'b0;
   logic modeSelIn = 1'b0;
   logic softResetIn = 1'b0;
   logic offhookOut, monitorOut, txMuteOut, rxMuteOut;
   logic linePowerdownOut, sysPowerdownOut, irqOut;
   logic [1:0] txAttenOut, rxAttenOut;
   logic [31:0] q;
   int num_errors = 0;
   int n_tests = 0;
   always #2.5 clk_sys = ~clk_sys;
   dlc_line_control_regs #(.RING_HOLD(32'd100), .OFFHOOK_TIMEOUT(32'd100))
      dlc_line_control_regs_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ringNegIn(ringNegIn),
      .ringPosIn(ringPosIn), .offhookPinIn(offhookPinIn), .modeSelIn(modeSelIn),
      .softResetIn(softResetIn), .offhookOut(offhookOut), .monitorOut(monitorOut),
      .txAttenOut(txAttenOut), .rxAttenOut(rxAttenOut), .txMuteOut(txMuteOut),
      .rxMuteOut(rxMuteOut), .linePowerdownOut(linePowerdownOut),
      .sysPowerdownOut(sysPowerdownOut), .irqOut(irqOut));
   dlc_line_model dlc_line_model_i (.clk_sys(clk_sys), .ringPos(ringPosIn),
      .ringNeg(ringNegIn));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      chk(pslverr, 1'b0, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk(1'b0, 1'b1, "no pready");
         complete_run();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(q, e, m);
   endtask
   // Waits a bounded time for the hook output to reach a level.
   task automatic wait_hook(input logic e, input int lim, input string m);
      int n;
      n = 0;
      while (offhookOut !== e && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk(offhookOut, e, m);
      if (offhookOut !== e) begin
         complete_run();
      end
   endtask
   task automatic t_reset();
      rd(dlc_pkg::ADDR_LINE_CTRL, 32'h0, "line reset");
      rd(dlc_pkg::ADDR_LEVEL_CTRL, 32'h70, "level reset");
      chk({txMuteOut, rxMuteOut, linePowerdownOut}, 3'b111, "reset outs");
      apb(1'b1, dlc_pkg::ADDR_RSVD7, 32'hff);
      rd(dlc_pkg::ADDR_RSVD7, 32'h0, "reserved");
      $display("test reset done");
   endtask
   task automatic t_levels();
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {1'b0, i[1], i[1], 1'b1, 2'b00, i[0], i[0]};
         apb(1'b1, dlc_pkg::ADDR_LEVEL_CTRL, {24'h0, v});
         repeat (2) @(posedge clk_sys);
         chk({txAttenOut, rxAttenOut}, {i[1:0], i[1:0]}, "atten codes");
         chk({txMuteOut, rxMuteOut, linePowerdownOut}, {i == 2, i == 2, 1'b1}, "mute pd");
      end
      apb(1'b1, dlc_pkg::ADDR_LEVEL_CTRL, 32'hff);
      rd(dlc_pkg::ADDR_LEVEL_CTRL, 32'h7b, "level mask");
      apb(1'b1, dlc_pkg::ADDR_LEVEL_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk({linePowerdownOut, sysPowerdownOut}, 2'b01, "pd bits");
      rd(dlc_pkg::ADDR_LEVEL_CTRL, 32'h08, "sys pd stays");
      softResetIn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      softResetIn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk({linePowerdownOut, sysPowerdownOut}, 2'b10, "pd after reset");
      $display("test levels done");
   endtask
   task automatic t_ring();
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h08);
      repeat (2) @(posedge clk_sys);
      chk(monitorOut, 1'b1, "monitor on");
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'hf6);
      repeat (2) @(posedge clk_sys);
      chk(monitorOut, 1'b0, "monitor off");
      fork
         dlc_line_model_i.ring(1'b1, 20);
         begin
            repeat (10) @(posedge clk_sys);
            rd(dlc_pkg::ADDR_LINE_CTRL, 32'h24, "pos ring");
         end
      join
      repeat (5) @(posedge clk_sys);
      rd(dlc_pkg::ADDR_LINE_CTRL, 32'h04, "ring held");
      repeat (130) @(posedge clk_sys);
      rd(dlc_pkg::ADDR_LINE_CTRL, 32'h00, "ring expired");
      rd(dlc_pkg::ADDR_IRQ_STATUS, 32'h03, "irq status");
      apb(1'b1, dlc_pkg::ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(irqOut, 1'b0, "irq masked");
      apb(1'b1, dlc_pkg::ADDR_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk_sys);
      chk(irqOut, 1'b1, "irq unmasked");
      apb(1'b1, dlc_pkg::ADDR_IRQ_STATUS, 32'h7);
      rd(dlc_pkg::ADDR_IRQ_STATUS, 32'h0, "irq clear");
      chk(irqOut, 1'b0, "irq low");
      fork
         dlc_line_model_i.ring(1'b0, 20);
         begin
            repeat (10) @(posedge clk_sys);
            rd(dlc_pkg::ADDR_LINE_CTRL, 32'h44, "neg ring");
         end
      join
      // Monitor mode is already off before the hook request.
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h01);
      repeat (2) @(posedge clk_sys);
      rd(dlc_pkg::ADDR_LINE_CTRL, 32'h01, "offhook clears ring");
      $display("test ring done");
   endtask
   task automatic t_hook();
      wait_hook(1'b1, 4, "hook up");
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h0);
      wait_hook(1'b0, 4, "hook down");
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h01);
      repeat (10) @(posedge clk_sys);
      chk(offhookOut, 1'b0, "timeout blocks");
      wait_hook(1'b1, 200, "after timeout");
      modeSelIn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h0);
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h01);
      wait_hook(1'b1, 4, "no timeout");
      apb(1'b1, dlc_pkg::ADDR_LINE_CTRL, 32'h0);
      offhookPinIn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(offhookOut, 1'b0, "pin disabled");
      apb(1'b1, dlc_pkg::ADDR_PIN_CTRL, 32'h1);
      wait_hook(1'b1, 6, "pin or");
      offhookPinIn <= 1'b0;
      wait_hook(1'b0, 8, "pin released");
      $display("test hook done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_levels();
      t_ring();
      t_hook();
      complete_run();
   end
endmodule
